// >>> hdl/irq_prio_ctrl.sv
// Interrupt priority, external edge, timer0 wrap and port-change logic.
// Assumes peripheral flags/enables and core context arrive synchronous to core_clk_i.
`timescale 1ns/10ps
`default_nettype none

module irq_prio_ctrl (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [irq_prio_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [irq_prio_pkg::DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [irq_prio_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [irq_prio_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [irq_prio_pkg::PERIPH_W-1:0] periph_flag_i,
    input wire logic [irq_prio_pkg::PERIPH_W-1:0] periph_enable_i,
    input wire logic [irq_prio_pkg::EXT_W-1:0] ext_pin_i,
    input wire logic [15:0] timer0_count_i,
    input wire logic timer0_16bit_i,
    input wire logic [3:0] port_change_pins_i,
    input wire logic port_read_i,
    input wire logic sleep_i,
    input wire logic irq_taken_i,
    input wire logic [irq_prio_pkg::PC_W-1:0] return_pc_i,
    input wire logic [7:0] working_register_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] bank_select_register_i,
    output logic irq_high_o,
    output logic irq_low_o,
    output logic wake_o,
    output logic vector_branch_o,
    output logic stack_push_o,
    output logic [irq_prio_pkg::PC_W-1:0] stack_pc_o,
    output logic [7:0] shadow_working_o,
    output logic [7:0] shadow_status_o,
    output logic [7:0] shadow_bank_select_o
);
    import irq_prio_pkg::*;

    // Masked byte write; unimplemented bits keep zero
    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] data,
                                           input logic [7:0] mask);
        wr_byte = (old & ~mask) | (data & mask);
    endfunction : wr_byte

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic wr_fire;
    logic [7:0] ctrl_first;
    logic [7:0] ctrl_second;
    logic [7:0] ctrl_third;
    logic [7:0] prio_a;
    logic [7:0] prio_b;
    logic [7:0] prio_c;
    logic [7:0] reset_status_control;
    logic [7:0] next_rdata;
    logic rd_hit;

    assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;

    // Address and data taken independently, one write in flight
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
        end else begin
            s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o);
            s_axi_wready_o <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o);
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata_i[7:0];
                w_lane <= s_axi_wstrb_i[0];
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response follows both halves
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= (aw_addr[1:0] == 2'b00 && aw_addr <= OFF_RESET_STATUS)
                             ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Read mux; unmapped reads zero with an error answer
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr_i)
            OFF_CTRL_FIRST: next_rdata = ctrl_first;
            OFF_CTRL_SECOND: next_rdata = ctrl_second;
            OFF_CTRL_THIRD: next_rdata = ctrl_third;
            OFF_PRIO_A: next_rdata = prio_a;
            OFF_PRIO_B: next_rdata = prio_b;
            OFF_PRIO_C: next_rdata = prio_c;
            OFF_RESET_STATUS: next_rdata = reset_status_control & MASK_RSC_READ;
            default: begin
                next_rdata = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // One-cycle read answer, held until taken
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else begin
            s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= {24'h000000, next_rdata};
                s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority and reset-status registers
    logic wr_ok;
    assign wr_ok = wr_fire && w_lane;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prio_a <= RST_PRIO_A;
            prio_b <= RST_PRIO_B;
            prio_c <= RST_PRIO_C;
            reset_status_control <= RST_RSC;
        end else if (wr_ok) begin
            if (aw_addr == OFF_PRIO_A) prio_a <= wr_byte(prio_a, w_byte, MASK_PRIO_A);
            if (aw_addr == OFF_PRIO_B) prio_b <= wr_byte(prio_b, w_byte, MASK_PRIO_B);
            if (aw_addr == OFF_PRIO_C) prio_c <= wr_byte(prio_c, w_byte, MASK_PRIO_C);
            if (aw_addr == OFF_RESET_STATUS) begin
                reset_status_control <= wr_byte(reset_status_control, w_byte,
                                                MASK_RSC_WRITE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source event detection
    logic [EXT_W-1:0] ext_prev;
    logic [15:0] t0_prev;
    logic [3:0] port_snapshot;
    logic [EXT_W-1:0] edge_sel;
    logic [EXT_W-1:0] ext_hit;
    logic t0_wrap;
    logic port_mismatch;

    assign edge_sel = ctrl_second[BIT_EDGE_LO +: EXT_W];
    // Rising when select is one, falling otherwise
    assign ext_hit = (edge_sel & ext_pin_i & ~ext_prev)
                   | (~edge_sel & ~ext_pin_i & ext_prev);
    // Wrap check compares last and current count
    assign t0_wrap = timer0_16bit_i ? (t0_prev == 16'hffff && timer0_count_i == 16'h0000)
                                    : (t0_prev[7:0] == 8'hff
                                       && timer0_count_i[7:0] == 8'h00);
    // Mismatch persists until the port is read
    assign port_mismatch = |(port_change_pins_i ^ port_snapshot);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_prev <= '0;
            t0_prev <= 16'h0000;
            port_snapshot <= 4'h0;
        end else begin
            ext_prev <= ext_pin_i;
            t0_prev <= timer0_count_i;
            if (port_read_i) port_snapshot <= port_change_pins_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers: hardware set wins over software clear
    logic [7:0] set_first;
    logic [7:0] set_third;
    assign set_first = {5'b00000, t0_wrap, ext_hit[0], port_mismatch};
    assign set_third = {5'b00000, ext_hit[3:1]};

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_first <= RST_CTRL;
            ctrl_second <= RST_CTRL_SECOND;
            ctrl_third <= RST_CTRL;
        end else begin
            ctrl_first <= ((wr_ok && aw_addr == OFF_CTRL_FIRST) ? w_byte : ctrl_first)
                          | set_first;
            ctrl_third <= ((wr_ok && aw_addr == OFF_CTRL_THIRD) ? w_byte : ctrl_third)
                          | set_third;
            if (wr_ok && aw_addr == OFF_CTRL_SECOND) ctrl_second <= w_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request routing
    logic [EXT_W-1:0] ext_flag;
    logic [EXT_W-1:0] ext_en;
    logic [EXT_W-1:0] ext_prio;
    logic [PERIPH_W-1:0] periph_prio;
    logic [PERIPH_W-1:0] periph_pend;
    logic [5:0] core_pend;
    logic [5:0] core_prio;
    logic prio_mode;
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic next_high;
    logic next_low;

    assign prio_mode = reset_status_control[BIT_PRIO_EN];
    assign global_irq_enable = ctrl_first[BIT_GLOBAL_EN];
    assign peripheral_irq_enable = ctrl_first[BIT_PERIPH_EN];
    assign ext_flag = {ctrl_third[BIT_EXT_FLAG_LO +: 3], ctrl_first[BIT_EXT0_FLAG]};
    assign ext_en = {ctrl_third[BIT_EXT_EN_LO +: 3], ctrl_first[BIT_EXT0_EN]};
    assign ext_prio = {ctrl_second[BIT_EXT3_PRIO], ctrl_third[BIT_EXT2_PRIO],
                       ctrl_third[BIT_EXT1_PRIO], 1'b1};
    assign periph_prio = {prio_a, prio_b & MASK_PRIO_B, prio_c & MASK_PRIO_C};
    assign periph_pend = periph_flag_i & periph_enable_i
                       & {MASK_PRIO_A, MASK_PRIO_B, MASK_PRIO_C};
    assign core_pend = {ext_flag & ext_en,
                        ctrl_first[BIT_T0_FLAG] & ctrl_first[BIT_T0_EN],
                        ctrl_first[BIT_PORT_FLAG] & ctrl_first[BIT_PORT_EN]};
    assign core_prio = {ext_prio, ctrl_second[BIT_T0_PRIO],
                        ctrl_second[BIT_PORT_PRIO]};

    // Two-level mode splits by priority; low level gated by peripheral enable
    always_comb begin
        if (prio_mode) begin
            next_high = global_irq_enable && (|(core_pend & core_prio) || |(periph_pend & periph_prio));
            next_low = global_irq_enable && peripheral_irq_enable
                       && (|(core_pend & ~core_prio) || |(periph_pend & ~periph_prio));
        end else begin
            next_high = global_irq_enable && (|core_pend || (peripheral_irq_enable && |periph_pend));
            next_low = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_high_o <= 1'b0;
            irq_low_o <= 1'b0;
            wake_o <= 1'b0;
            vector_branch_o <= 1'b0;
        end else begin
            irq_high_o <= next_high;
            irq_low_o <= next_low;
            wake_o <= sleep_i && |(ext_flag & ext_en);
            vector_branch_o <= sleep_i && |(ext_flag & ext_en) && global_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Context capture when the core takes an interrupt
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stack_push_o <= 1'b0;
            stack_pc_o <= '0;
            shadow_working_o <= 8'h00;
            shadow_status_o <= 8'h00;
            shadow_bank_select_o <= 8'h00;
        end else begin
            stack_push_o <= irq_taken_i;
            if (irq_taken_i) begin
                stack_pc_o <= return_pc_i;
                shadow_working_o <= working_register_i;
                shadow_status_o <= status_i;
                shadow_bank_select_o <= bank_select_register_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_rise0;
        edge_sel[0] && ext_pin_i[0] && !ext_prev[0];
    endsequence
    sequence s_fall1;
        !edge_sel[1] && !ext_pin_i[1] && ext_prev[1];
    endsequence

    property p_rise_sets;
        s_rise0 |=> ctrl_first[BIT_EXT0_FLAG];
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");
    property p_fall_sets;
        s_fall1 |=> ctrl_third[BIT_EXT_FLAG_LO];
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");
    property p_single_no_low;
        !prio_mode |=> !irq_low_o;
    endproperty
    a_single_no_low: assert property (p_single_no_low) else $error("low request in single mode");
    property p_ext0_high;
        prio_mode && global_irq_enable && ext_flag[0] && ext_en[0] |=> irq_high_o;
    endproperty
    a_ext0_high: assert property (p_ext0_high) else $error("ext zero not high");
    property p_t0_wrap8;
        !timer0_16bit_i && t0_prev[7:0] == 8'hff && timer0_count_i[7:0] == 8'h00
            |=> ctrl_first[BIT_T0_FLAG];
    endproperty
    a_t0_wrap8: assert property (p_t0_wrap8) else $error("timer0 wrap missed");
    property p_push;
        irq_taken_i |=> stack_push_o && stack_pc_o == $past(return_pc_i);
    endproperty
    a_push: assert property (p_push) else $error("return pc not pushed");
    property p_shadow;
        irq_taken_i |=> shadow_working_o == $past(working_register_i)
                        && shadow_bank_select_o == $past(bank_select_register_i);
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow not captured");
    property p_reserved_zero;
        prio_b[7] == 1'b0 && prio_b[5] == 1'b0 && prio_c[7:6] == 2'b00
            && reset_status_control[6:5] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
    property p_branch;
        vector_branch_o |-> wake_o && $past(global_irq_enable);
    endproperty
    a_branch: assert property (p_branch) else $error("branch without global enable");
    property p_read_lat;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read answer late");
endmodule : irq_prio_ctrl

`default_nettype wire

// >>> hdl/irq_prio_pkg.sv
// Constants for the interrupt priority and source-flag block.
// Assumes an AXI4-Lite master with 32-bit data and one 100 MHz clock.
package irq_prio_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PERIPH_W = 24;
    localparam int EXT_W = 4;
    localparam int PC_W = 21;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL_FIRST = 8'h00;
    localparam logic [7:0] OFF_CTRL_SECOND = 8'h04;
    localparam logic [7:0] OFF_CTRL_THIRD = 8'h08;
    localparam logic [7:0] OFF_PRIO_A = 8'h0c;
    localparam logic [7:0] OFF_PRIO_B = 8'h10;
    localparam logic [7:0] OFF_PRIO_C = 8'h14;
    localparam logic [7:0] OFF_RESET_STATUS = 8'h18;

    // Implemented-bit masks and reset values
    localparam logic [7:0] MASK_PRIO_A = 8'hff;
    localparam logic [7:0] MASK_PRIO_B = 8'h5f;
    localparam logic [7:0] MASK_PRIO_C = 8'h3f;
    localparam logic [7:0] RST_PRIO_A = 8'hff;
    localparam logic [7:0] RST_PRIO_B = 8'h5f;
    localparam logic [7:0] RST_PRIO_C = 8'h3f;
    localparam logic [7:0] MASK_RSC_READ = 8'h9f;
    localparam logic [7:0] MASK_RSC_WRITE = 8'h93;
    localparam logic [7:0] RST_RSC = 8'h1c;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_CTRL_SECOND = 8'h7f;

    // Field positions
    localparam int BIT_PRIO_EN = 7;
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PERIPH_EN = 6;
    localparam int BIT_T0_EN = 5;
    localparam int BIT_EXT0_EN = 4;
    localparam int BIT_PORT_EN = 3;
    localparam int BIT_T0_FLAG = 2;
    localparam int BIT_EXT0_FLAG = 1;
    localparam int BIT_PORT_FLAG = 0;
    localparam int BIT_EDGE_LO = 3;
    localparam int BIT_T0_PRIO = 2;
    localparam int BIT_EXT3_PRIO = 1;
    localparam int BIT_PORT_PRIO = 0;
    localparam int BIT_EXT2_PRIO = 7;
    localparam int BIT_EXT1_PRIO = 6;
    localparam int BIT_EXT_EN_LO = 3;
    localparam int BIT_EXT_FLAG_LO = 0;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : irq_prio_pkg

// >>> verif/core_model.sv
// Core-side partner: takes a pending request once and offers its context.
// Assumes registered request levels on the block's own clock.
`timescale 1ns/10ps
`default_nettype none
module core_model #(
    parameter logic [20:0] PC_VAL = 21'h0a5c3e,
    parameter logic [7:0] W_VAL = 8'h5a,
    parameter logic [7:0] S_VAL = 8'hc3,
    parameter logic [7:0] B_VAL = 8'h0e
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic req_i,
    output logic taken_o,
    output logic [20:0] pc_o,
    output logic [7:0] w_o,
    output logic [7:0] st_o,
    output logic [7:0] bsr_o
);
    logic served;

    // One take per request, so a held level is not pushed twice
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            taken_o <= 1'b0;
            served <= 1'b0;
        end else begin
            taken_o <= req_i && !served;
            served <= req_i;
        end
    end

    // Context valid only with the take; inverted otherwise to expose stale capture
    assign pc_o = taken_o ? PC_VAL : ~PC_VAL;
    assign w_o = taken_o ? W_VAL : ~W_VAL;
    assign st_o = taken_o ? S_VAL : ~S_VAL;
    assign bsr_o = taken_o ? B_VAL : ~B_VAL;
endmodule : core_model
`default_nettype wire

// >>> verif/irq_prio_ctrl_test.sv
// Self-checking bench for the interrupt priority block.
// Assumes the package and the core partner model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module irq_prio_ctrl_test;
    import irq_prio_pkg::*;
    localparam logic [20:0] PC_VAL = 21'h0a5c3e;
    localparam logic [7:0] W_VAL = 8'h5a, S_VAL = 8'hc3, B_VAL = 8'h0e;
    logic core_clk_i = 1'b0, arst_n_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic timer0_16bit_i = 1'b0, port_read_i = 1'b0, sleep_i = 1'b0, irq_taken_i;
    logic [ADDR_W-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
    logic [DATA_W-1:0] s_axi_wdata_i = '0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hf, ext_pin_i = 4'h0, port_change_pins_i = 4'h0;
    logic [PERIPH_W-1:0] periph_flag_i = '0, periph_enable_i = '0;
    logic [15:0] timer0_count_i = 16'h0000;
    logic [PC_W-1:0] return_pc_i, stack_pc_o;
    logic [7:0] working_register_i, status_i, bank_select_register_i;
    logic [7:0] shadow_working_o, shadow_status_o, shadow_bank_select_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic irq_high_o, irq_low_o, wake_o, vector_branch_o, stack_push_o;
    int n_fail = 0, comparisons = 0;

    always #5 core_clk_i = ~core_clk_i;

    irq_prio_ctrl irq_prio_ctrl_i (.core_clk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
        .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .periph_flag_i, .periph_enable_i, .ext_pin_i, .timer0_count_i, .timer0_16bit_i,
        .port_change_pins_i, .port_read_i, .sleep_i, .irq_taken_i, .return_pc_i,
        .working_register_i, .status_i, .bank_select_register_i, .irq_high_o, .irq_low_o,
        .wake_o, .vector_branch_o, .stack_push_o, .stack_pc_o, .shadow_working_o,
        .shadow_status_o, .shadow_bank_select_o);

    core_model #(.PC_VAL(PC_VAL), .W_VAL(W_VAL), .S_VAL(S_VAL), .B_VAL(B_VAL)) core_model_i (
        .clk_i(core_clk_i), .arst_n_i, .req_i(irq_high_o | irq_low_o), .taken_o(irq_taken_i),
        .pc_o(return_pc_i), .w_o(working_register_i), .st_o(status_i),
        .bsr_o(bank_select_register_i));

    ////////////////////////////////////////
    // Verdict, compare and wait helpers
    task automatic print_verdict;
        $display("Counts: %0d compared, %0d failed", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : ck

    task automatic hang;
        n_fail++;
        $display("BAD at %0t: no bus answer", $time);
        print_verdict();
    endtask : hang

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick

    // Bus write; the leading edge keeps a driver from changing twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
        logic got = 1'b0;
        tick(1);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'h000000, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge core_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o) begin
                s_axi_bready_i <= 1'b0;
                got = 1'b1;
                ck({30'h0, s_axi_bresp_o}, {30'h0, er});
            end
        end
        if (!got) hang();
    endtask : wr

    // Bus read with compare of data and response code
    task automatic rck(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = 2'b00);
        logic got = 1'b0;
        tick(1);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge core_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o) begin
                s_axi_rready_i <= 1'b0;
                got = 1'b1;
                ck(s_axi_rdata_o, {24'h000000, e});
                ck({30'h0, s_axi_rresp_o}, {30'h0, er});
            end
        end
        if (!got) hang();
    endtask : rck

    ////////////////////////////////////////
    // Scenarios
    task automatic t_regs;
        rck(OFF_PRIO_A, 8'hff);
        rck(OFF_PRIO_B, 8'h5f);
        rck(OFF_PRIO_C, 8'h3f);
        rck(OFF_RESET_STATUS, 8'h1c);
        wr(OFF_PRIO_B, 8'ha0);
        rck(OFF_PRIO_B, 8'h00);
        wr(OFF_PRIO_C, 8'hc5);
        rck(OFF_PRIO_C, 8'h05);
        wr(OFF_RESET_STATUS, 8'h60);
        rck(OFF_RESET_STATUS, 8'h0c);
        wr(OFF_PRIO_A, 8'h5a);
        rck(OFF_PRIO_A, 8'h5a);
        rck(8'h40, 8'h00, RESP_SLVERR);
        wr(8'h40, 8'h55, RESP_SLVERR);
        $display("regs done");
    endtask : t_regs

    // Edges, wake, vector, context save
    task automatic t_ext;
        wr(OFF_CTRL_SECOND, 8'h08);
        ext_pin_i <= 4'he;
        tick(4);
        rck(OFF_CTRL_THIRD, 8'h00);
        ext_pin_i <= 4'h1;
        tick(4);
        rck(OFF_CTRL_FIRST, 8'h02);
        rck(OFF_CTRL_THIRD, 8'h07);
        wr(OFF_CTRL_FIRST, 8'h00);
        wr(OFF_CTRL_THIRD, 8'h00);
        ext_pin_i <= 4'he;
        tick(4);
        rck(OFF_CTRL_FIRST, 8'h00);
        sleep_i <= 1'b1;
        wr(OFF_RESET_STATUS, 8'h80);
        wr(OFF_CTRL_FIRST, 8'h90);
        ext_pin_i <= 4'hf;
        tick(4);
        ck(wake_o, 32'h1);
        ck(vector_branch_o, 32'h1);
        ck({irq_high_o, irq_low_o}, 32'h2);
        tick(1);
        ck(stack_push_o, 32'h1);
        ck(stack_pc_o, {11'h000, PC_VAL});
        ck({shadow_working_o, shadow_status_o, shadow_bank_select_o},
            {8'h00, W_VAL, S_VAL, B_VAL});
        // Saved status must stand for the service routine after the take
        tick(3);
        ck(shadow_status_o, S_VAL);
        sleep_i <= 1'b0;
        wr(OFF_CTRL_FIRST, 8'h00);
        $display("ext done");
    endtask : t_ext

    // Peripheral routing; priority A bit 0 is low
    task automatic t_periph;
        periph_enable_i <= 24'h010000;
        periph_flag_i <= 24'h010000;
        wr(OFF_CTRL_FIRST, 8'hc0);
        tick(4);
        ck({irq_high_o, irq_low_o}, 32'h1);
        wr(OFF_RESET_STATUS, 8'h00);
        tick(4);
        ck({irq_high_o, irq_low_o}, 32'h2);
        wr(OFF_CTRL_FIRST, 8'h80);
        tick(4);
        ck(irq_high_o, 32'h0);
        periph_flag_i <= 24'h000000;
        wr(OFF_RESET_STATUS, 8'h80);
        wr(OFF_CTRL_FIRST, 8'h00);
        $display("periph done");
    endtask : t_periph

    // Timer wrap in both modes, then its priority
    task automatic t_timer;
        timer0_16bit_i <= 1'b1;
        timer0_count_i <= 16'h00ff;
        tick(1);
        timer0_count_i <= 16'h0100;
        tick(3);
        rck(OFF_CTRL_FIRST, 8'h00);
        timer0_count_i <= 16'hffff;
        tick(1);
        timer0_count_i <= 16'h0000;
        tick(3);
        rck(OFF_CTRL_FIRST, 8'h04);
        wr(OFF_CTRL_FIRST, 8'h00);
        timer0_16bit_i <= 1'b0;
        timer0_count_i <= 16'h00ff;
        tick(1);
        timer0_count_i <= 16'h0000;
        tick(3);
        rck(OFF_CTRL_FIRST, 8'h04);
        wr(OFF_CTRL_SECOND, 8'h0c);
        wr(OFF_CTRL_FIRST, 8'he4);
        tick(4);
        ck({irq_high_o, irq_low_o}, 32'h2);
        wr(OFF_CTRL_SECOND, 8'h08);
        tick(4);
        ck({irq_high_o, irq_low_o}, 32'h1);
        wr(OFF_CTRL_FIRST, 8'h00);
        $display("timer done");
    endtask : t_timer

    // Port change: mismatch sets the flag, a port read ends it
    task automatic t_port;
        port_change_pins_i <= 4'h9;
        tick(4);
        rck(OFF_CTRL_FIRST, 8'h01);
        port_read_i <= 1'b1;
        tick(1);
        port_read_i <= 1'b0;
        wr(OFF_CTRL_FIRST, 8'h08);
        tick(3);
        rck(OFF_CTRL_FIRST, 8'h08);
        $display("port done");
    endtask : t_port

    initial begin
        tick(6);
        arst_n_i <= 1'b1;
        t_regs();
        t_ext();
        t_periph();
        t_timer();
        t_port();
        print_verdict();
    end
endmodule : irq_prio_ctrl_test
`default_nettype wire
